// ### logic/servo_readout_defs.svh
// Constants for the servo position readout sequencer
//
// Contract
// - Stroke limit: refuse pulses, zero droop, halt
// - Reply position as 32-bit hexadecimal characters
// - Read loads position as position command; not while a stroke limit is active
// - Base circuit on after servo-on delay
// - Ready only after base circuit is on
// - Serial fault answers with error code
// - Forced stop release: base delay, then ready
// - Warn when request missing after ready high
`ifndef SERVO_READOUT_DEFS_SVH
`define SERVO_READOUT_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ      125000
`define MS_CYCLES         (`CLK_FREQ_KHZ)
`define BASE_DLY_MS       95
`define ESTOP_BASE_DLY_MS 210
`define RDY_DLY_MS        5
`define XFER_TMO_S        5
`define XFER_TMO_MS       (`XFER_TMO_S * 1000)
`define MS_CNT_W          13

// ----------------------------------------------------------------
// Serial command codes and reply layout
// ----------------------------------------------------------------
`define CMD_READ_POS      8'h02
`define DATA_NO_POS       8'h91
`define ERR_CODE_BAD      8'h01
`define REPLY_NIBBLES     3'h7
`define ASCII_ZERO        8'h30
`define ASCII_A_MINUS_10  8'h37
`define POS_W             32
`endif

// ### logic/servo_readout_pkg.sv
// Types shared by the servo position readout sequencer
package servo_readout_pkg;
    // Power-stage sequencing states
    typedef enum logic [1:0] {
        S_OFF       = 2'b00,
        S_WAIT_BASE = 2'b01,
        S_WAIT_RDY  = 2'b10,
        S_RUN       = 2'b11
    } seq_state_t;
endpackage : servo_readout_pkg

// ### logic/servo_position_readout_seq.sv
// Power sequencing, stroke-end handling, serial position reply, transfer timeout
`timescale 1ns/1ps
`include "servo_readout_defs.svh"
module servo_position_readout_seq
    import servo_readout_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES  // Clock cycles per millisecond tick
) (
    input  wire logic        CORE_CLK,
    input  wire logic        ARST_N,
    input  wire logic        SERVO_ON_INPUT,
    input  wire logic        FORCED_STOP_INPUT,
    input  wire logic        ALARM_CAUSE,
    input  wire logic        FORWARD_STROKE_LIMIT,
    input  wire logic        REVERSE_STROKE_LIMIT,
    input  wire logic        CMD_PULSE,
    input  wire logic        CMD_DIR,
    input  wire logic        FB_PULSE,
    input  wire logic        FB_DIR,
    input  wire logic [7:0]  STATION_ADDR,
    input  wire logic        READ_REQ,
    input  wire logic [7:0]  READ_STATION,
    input  wire logic [7:0]  READ_CMD,
    input  wire logic [7:0]  READ_DATA_NO,
    input  wire logic        READ_FRAME_ERR,
    input  wire logic        POSITION_TRANSFER_MODE,
    input  wire logic        POSITION_REQUEST,
    output logic             BASE_ON,
    output logic             READY_OUT,
    output logic             ALARM_OUTPUT,
    output logic             PULSE_INHIBIT,
    output logic             MOTOR_HALT,
    output logic [31:0]      DROOP_COUNT,
    output logic [31:0]      POSITION_COMMAND,
    output logic             REPLY_VALID,
    output logic [7:0]       REPLY_CHAR,
    output logic             REPLY_LAST,
    output logic             REPLY_ERROR,
    output logic [7:0]       REPLY_ERR_CODE,
    output logic             TRANSFER_DATA_READY,
    output logic             TRANSFER_TIMEOUT_WARNING
);

    // ------------------------------------------------------------
    // Millisecond timebase
    // ------------------------------------------------------------
    logic [16:0] ms_div_q, ms_div_d;    // Cycle divider
    logic        ms_tick;               // One-cycle pulse each ms

    // Divider next value
    always_comb begin
        ms_tick  = (ms_div_q == 17'(MS_CYCLES - 1));
        ms_div_d = ms_tick ? 17'h0 : ms_div_q + 17'h1;
    end

    // Divider register
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) ms_div_q <= 17'h0;
        else         ms_div_q <= ms_div_d;
    end

    // ------------------------------------------------------------
    // Power-stage sequencer
    // ------------------------------------------------------------
    seq_state_t             state_q, state_d;     // Sequencer state
    logic [`MS_CNT_W-1:0]   seq_cnt_q, seq_cnt_d; // Ms within a wait
    logic                   est_q, est_d;         // Forced stop was seen
    logic                   alarm_q, alarm_d;     // Alarm output
    logic                   base_q, base_d;       // Base circuit on
    logic                   rdy_q, rdy_d;         // Ready output
    logic                   stop_cond;            // Any reason to stay off
    logic [`MS_CNT_W-1:0]   base_dly;             // Selected base delay

    // Sequencer next state
    always_comb begin
        state_d   = state_q;
        seq_cnt_d = seq_cnt_q;
        est_d     = est_q | FORCED_STOP_INPUT;
        alarm_d   = ALARM_CAUSE;
        base_d    = base_q;
        rdy_d     = rdy_q;
        stop_cond = !SERVO_ON_INPUT || FORCED_STOP_INPUT || ALARM_CAUSE;
        base_dly  = est_q ? `MS_CNT_W'(`ESTOP_BASE_DLY_MS)
                          : `MS_CNT_W'(`BASE_DLY_MS);
        if (stop_cond) begin
            // Drop everything at once
            state_d   = S_OFF;
            base_d    = 1'b0;
            rdy_d     = 1'b0;
            seq_cnt_d = '0;
        end else begin
            unique case (state_q)
                S_OFF: begin
                    state_d   = S_WAIT_BASE;
                    seq_cnt_d = '0;
                end
                S_WAIT_BASE: begin
                    // Count ms, then switch base on
                    if (ms_tick) begin
                        if (seq_cnt_q == base_dly - `MS_CNT_W'(1)) begin
                            base_d    = 1'b1;
                            est_d     = 1'b0;
                            seq_cnt_d = '0;
                            state_d   = S_WAIT_RDY;
                        end else begin
                            seq_cnt_d = seq_cnt_q + `MS_CNT_W'(1);
                        end
                    end
                end
                S_WAIT_RDY: begin
                    // Ready follows base by the ready delay
                    if (ms_tick) begin
                        if (seq_cnt_q == `MS_CNT_W'(`RDY_DLY_MS - 1)) begin
                            rdy_d   = base_q;
                            state_d = S_RUN;
                        end else begin
                            seq_cnt_d = seq_cnt_q + `MS_CNT_W'(1);
                        end
                    end
                end
                S_RUN: begin
                    // Hold until a stop condition
                    state_d = S_RUN;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q   <= S_OFF;
            seq_cnt_q <= '0;
            est_q     <= 1'b0;
            alarm_q   <= 1'b0;
            base_q    <= 1'b0;
            rdy_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            seq_cnt_q <= seq_cnt_d;
            est_q     <= est_d;
            alarm_q   <= alarm_d;
            base_q    <= base_d;
            rdy_q     <= rdy_d;
        end
    end

    // ------------------------------------------------------------
    // Position, command and droop tracking
    // ------------------------------------------------------------
    logic [31:0] cur_pos_q, cur_pos_d;   // Actual position
    logic [31:0] cmd_q, cmd_d;           // Position command
    logic [31:0] droop_q, droop_d;       // Accumulated droop
    logic        inh_q, inh_d;           // Pulse inhibit
    logic        limit_hit;              // Either stroke limit
    logic        good_read;              // Valid position read
    logic        bad_read;               // Faulty frame for us

    // Position next values
    always_comb begin
        limit_hit = FORWARD_STROKE_LIMIT || REVERSE_STROKE_LIMIT;
        good_read = READ_REQ && (READ_STATION == STATION_ADDR) && !READ_FRAME_ERR
                    && (READ_CMD == `CMD_READ_POS) && (READ_DATA_NO == `DATA_NO_POS);
        bad_read  = READ_REQ && (READ_STATION == STATION_ADDR) && !good_read;
        inh_d     = limit_hit;
        cur_pos_d = cur_pos_q;
        cmd_d     = cmd_q;
        droop_d   = droop_q;
        if (FB_PULSE) begin
            cur_pos_d = FB_DIR ? cur_pos_q - 32'h1 : cur_pos_q + 32'h1;
        end
        if (limit_hit) begin
            // Refuse pulses and clear droop together
            droop_d = 32'h0;
        end else if (good_read) begin
            // Reply value becomes the command
            cmd_d   = cur_pos_q;
            droop_d = 32'h0;
        end else begin
            if (CMD_PULSE) begin
                cmd_d = CMD_DIR ? cmd_q - 32'h1 : cmd_q + 32'h1;
            end
            droop_d = droop_q + (CMD_PULSE ? (CMD_DIR ? 32'hffffffff : 32'h1) : 32'h0)
                              - (FB_PULSE ? (FB_DIR ? 32'hffffffff : 32'h1) : 32'h0);
        end
    end

    // Position registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cur_pos_q <= 32'h0;
            cmd_q     <= 32'h0;
            droop_q   <= 32'h0;
            inh_q     <= 1'b0;
        end else begin
            cur_pos_q <= cur_pos_d;
            cmd_q     <= cmd_d;
            droop_q   <= droop_d;
            inh_q     <= inh_d;
        end
    end

    // ------------------------------------------------------------
    // Serial reply
    // ------------------------------------------------------------
    logic [31:0] shf_q, shf_d;           // Latched reply value
    logic [2:0]  nib_q, nib_d;           // Nibbles left
    logic        rv_q, rv_d;             // Reply char valid
    logic [7:0]  rc_q, rc_d;             // Reply char
    logic        rl_q, rl_d;             // Last char
    logic        re_q, re_d;             // Error reply pulse
    logic [7:0]  ec_q, ec_d;             // Error code byte, zero when idle
    logic        busy;                   // Reply in progress
    logic [3:0]  nib;                    // Nibble to encode

    // Reply next values, most significant nibble first
    always_comb begin
        shf_d = shf_q;
        nib_d = nib_q;
        rv_d  = 1'b0;
        rc_d  = rc_q;
        rl_d  = 1'b0;
        re_d  = bad_read;
        ec_d  = bad_read ? `ERR_CODE_BAD : 8'h0;
        busy  = rv_q && !rl_q;
        nib   = 4'h0;
        if (good_read && !busy) begin
            // Start with the top nibble
            nib   = cur_pos_q[31:28];
            shf_d = {cur_pos_q[27:0], 4'h0};
            nib_d = `REPLY_NIBBLES - 3'h1;
            rv_d  = 1'b1;
        end else if (busy) begin
            // Shift out the remaining nibbles
            nib   = shf_q[31:28];
            shf_d = {shf_q[27:0], 4'h0};
            nib_d = nib_q - 3'h1;
            rv_d  = 1'b1;
            rl_d  = (nib_q == 3'h0);
        end
        if (rv_d) begin
            rc_d = (nib < 4'ha) ? `ASCII_ZERO + {4'h0, nib}
                                : `ASCII_A_MINUS_10 + {4'h0, nib};
        end
    end

    // Reply registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            shf_q <= 32'h0;
            nib_q <= 3'h0;
            rv_q  <= 1'b0;
            rc_q  <= 8'h0;
            rl_q  <= 1'b0;
            re_q  <= 1'b0;
            ec_q  <= 8'h0;
        end else begin
            shf_q <= shf_d;
            nib_q <= nib_d;
            rv_q  <= rv_d;
            rc_q  <= rc_d;
            rl_q  <= rl_d;
            re_q  <= re_d;
            ec_q  <= ec_d;
        end
    end

    // ------------------------------------------------------------
    // Transfer handshake timeout
    // ------------------------------------------------------------
    logic                 tdr_q, tdr_d;     // Transfer data ready
    logic                 mode_p_q;         // Previous mode level
    logic [`MS_CNT_W-1:0] xc_q, xc_d;       // Ms waiting for request
    logic                 warn_q, warn_d;   // Timeout warning

    // Timeout next values; a new timeout wins over the mode-rise clear
    always_comb begin
        tdr_d  = POSITION_TRANSFER_MODE && !POSITION_REQUEST;
        xc_d   = (tdr_q && !POSITION_REQUEST) ? xc_q : '0;
        warn_d = warn_q;
        if (POSITION_TRANSFER_MODE && !mode_p_q) begin
            warn_d = 1'b0;
        end
        if (tdr_q && !POSITION_REQUEST && ms_tick) begin
            if (xc_q == `MS_CNT_W'(`XFER_TMO_MS - 1)) begin
                warn_d = 1'b1;
            end else begin
                xc_d = xc_q + `MS_CNT_W'(1);
            end
        end
    end

    // Timeout registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tdr_q    <= 1'b0;
            mode_p_q <= 1'b0;
            xc_q     <= '0;
            warn_q   <= 1'b0;
        end else begin
            tdr_q    <= tdr_d;
            mode_p_q <= POSITION_TRANSFER_MODE;
            xc_q     <= xc_d;
            warn_q   <= warn_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign BASE_ON                  = base_q;
    assign READY_OUT                = rdy_q;
    assign ALARM_OUTPUT             = alarm_q;
    assign PULSE_INHIBIT            = inh_q;
    assign MOTOR_HALT               = inh_q;
    assign DROOP_COUNT              = droop_q;
    assign POSITION_COMMAND         = cmd_q;
    assign REPLY_VALID              = rv_q;
    assign REPLY_CHAR               = rc_q;
    assign REPLY_LAST               = rl_q;
    assign REPLY_ERROR              = re_q;
    assign REPLY_ERR_CODE           = ec_q;
    assign TRANSFER_DATA_READY      = tdr_q;
    assign TRANSFER_TIMEOUT_WARNING = warn_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_limit_stop: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        limit_hit |=> (PULSE_INHIBIT && MOTOR_HALT && DROOP_COUNT == 32'h0))
        else $error("stroke limit did not stop pulses");
    chk_reply_len: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $rose(REPLY_VALID) |-> (REPLY_VALID && !REPLY_LAST) [*7] ##1 (REPLY_VALID && REPLY_LAST)
        ##1 !REPLY_VALID)
        else $error("reply is not eight characters");
    chk_cmd_load: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (good_read && !limit_hit) |=> (POSITION_COMMAND == $past(cur_pos_q)))
        else $error("read did not load position command");
    chk_base_delay: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $rose(BASE_ON) |-> ($past(state_q) == S_WAIT_BASE && $past(seq_cnt_q) == $past(base_dly)
        - `MS_CNT_W'(1)))
        else $error("base circuit on at wrong time");
    chk_ready_base: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        READY_OUT |-> BASE_ON)
        else $error("ready without base circuit");
    chk_err_reply: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        bad_read |=> (REPLY_ERROR && REPLY_ERR_CODE == `ERR_CODE_BAD))
        else $error("faulty frame got no error code");
    chk_ready_gap: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $rose(READY_OUT) |-> ($past(BASE_ON) && $past(seq_cnt_q) == `MS_CNT_W'(`RDY_DLY_MS - 1)))
        else $error("ready gap after base is wrong");
    chk_xfer_warn: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $rose(TRANSFER_TIMEOUT_WARNING) |-> ($past(xc_q) == `MS_CNT_W'(`XFER_TMO_MS - 1)))
        else $error("transfer warning at wrong time");

endmodule : servo_position_readout_seq

// ### verif/servo_ctrl_model.sv
// Controller model: serial position reads, reply decoding and retries
`timescale 1ns/1ps
module servo_ctrl_model #(
    parameter logic [7:0] STATION = 8'h05  // Station number of the drive
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ready_out,
    input  wire logic        reply_valid,
    input  wire logic [7:0]  reply_char,
    input  wire logic        reply_last,
    input  wire logic        reply_error,
    input  wire logic [7:0]  reply_err_code,
    input  wire logic        kick,
    input  wire logic [7:0]  kick_station,
    input  wire logic [7:0]  kick_cmd,
    input  wire logic        kick_ferr,
    output logic             read_req,
    output logic [7:0]       read_station,
    output logic [7:0]       read_cmd,
    output logic [7:0]       read_data_no,
    output logic             read_frame_err,
    output logic [31:0]      got_pos,
    output logic [7:0]       got_code,
    output int               reads,
    output int               errs,
    output int               tmos
);
    logic        rdy_q;   // Ready seen last cycle
    logic        busy;    // Waiting for a reply
    logic        retry;   // Reissue pending
    int          wait_n;  // Cycles spent waiting
    int          tries;   // Retries used on this read
    logic [31:0] sh;      // Nibbles gathered so far
    logic [3:0]  nib;     // Current reply nibble
    assign nib = (reply_char >= 8'h41) ? 4'(reply_char - 8'h37) : 4'(reply_char - 8'h30);
    // Frame issue, reply capture, time-out and retry
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {rdy_q, busy, retry, read_req, read_frame_err} <= '0;
            {read_station, read_cmd, read_data_no, got_code} <= '0;
            {got_pos, sh, wait_n, tries, reads, errs, tmos} <= '0;
        end else begin
            rdy_q <= ready_out;
            read_req <= 1'b0;
            // Idle frame lines change every cycle so no stale value looks valid
            read_station <= ~read_station;
            read_cmd <= ~read_cmd;
            read_data_no <= ~read_data_no;
            read_frame_err <= ~read_frame_err;
            if (kick || retry || (ready_out && !rdy_q)) begin
                read_req <= 1'b1;
                busy <= 1'b1;
                retry <= 1'b0;
                wait_n <= 0;
                read_station <= kick ? kick_station : STATION;
                read_cmd <= kick ? kick_cmd : 8'h02;
                read_data_no <= 8'h91;
                read_frame_err <= kick & kick_ferr;
                if (!retry) tries <= 0;
            end else if (busy) begin
                wait_n <= wait_n + 1;
                if (wait_n == 20) begin
                    busy <= 1'b0;
                    tmos <= tmos + 1;
                    retry <= (tries < 3);
                    tries <= tries + 1;
                end
            end
            if (reply_valid) sh <= {sh[27:0], nib};
            if (reply_valid && reply_last) begin
                got_pos <= {sh[27:0], nib};
                reads <= reads + 1;
                busy <= 1'b0;
            end
            if (reply_error) begin
                got_code <= reply_err_code;
                errs <= errs + 1;
                busy <= 1'b0;
                retry <= (tries < 3);
                tries <= tries + 1;
            end
        end
    end
endmodule : servo_ctrl_model

// ### verif/servo_position_readout_seq_tb.sv
// Self-checking bench for the servo position readout sequencer
`timescale 1ns/1ps
module servo_position_readout_seq_tb;
    localparam int          M   = 4;             // Cycles per ms tick
    localparam logic [31:0] POS = 32'hfffffff6;  // Ten negative feedback counts
    logic        core_clk, arst_n, servo_on_input, estop, alarm, fwd, rev, cpul, cdir, fpul, fdir;
    logic        mode, preq, kick, kferr, rreq, rferr, base_on, ready, alarm_o;
    logic        inhibit, halt, rvalid, rlast, rerr, tdr, warn;
    logic [7:0]  kst, kcmd, rst_s, rcmd, rdno, rchar, rcode, gcode;
    logic [31:0] droop, pcmd, gpos;
    int          reads, errs, tmos, fail_count, total_checks, n, r0, e0;
    int          tdr_rises, tdr_low_n, tdr_low_max, req_hi_n, req_hi_max, mode_hi_n;
    logic        tdr_p;  // Transfer ready one cycle back

    // Controller-side transfer timers: ready rises, ready low, request high, mode high
    always @(posedge core_clk) begin
        tdr_p       <= tdr;
        tdr_rises   <= mode ? tdr_rises + int'(tdr && !tdr_p) : 0;
        tdr_low_n   <= (mode && !tdr) ? tdr_low_n + 1 : 0;
        tdr_low_max <= (tdr_low_n > tdr_low_max) ? tdr_low_n : tdr_low_max;
        req_hi_n    <= preq ? req_hi_n + 1 : 0;
        req_hi_max  <= (req_hi_n > req_hi_max) ? req_hi_n : req_hi_max;
        mode_hi_n   <= mode ? mode_hi_n + 1 : 0;
    end

    servo_position_readout_seq #(.MS_CYCLES(M)) dut (
        .CORE_CLK(core_clk), .ARST_N(arst_n), .SERVO_ON_INPUT(servo_on_input),
        .FORCED_STOP_INPUT(estop), .ALARM_CAUSE(alarm), .FORWARD_STROKE_LIMIT(fwd),
        .REVERSE_STROKE_LIMIT(rev), .CMD_PULSE(cpul), .CMD_DIR(cdir), .FB_PULSE(fpul),
        .FB_DIR(fdir), .STATION_ADDR(8'h05), .READ_REQ(rreq), .READ_STATION(rst_s),
        .READ_CMD(rcmd), .READ_DATA_NO(rdno), .READ_FRAME_ERR(rferr), .POSITION_TRANSFER_MODE(mode),
        .POSITION_REQUEST(preq), .BASE_ON(base_on), .READY_OUT(ready), .ALARM_OUTPUT(alarm_o),
        .PULSE_INHIBIT(inhibit), .MOTOR_HALT(halt), .DROOP_COUNT(droop), .POSITION_COMMAND(pcmd),
        .REPLY_VALID(rvalid), .REPLY_CHAR(rchar), .REPLY_LAST(rlast), .REPLY_ERROR(rerr),
        .REPLY_ERR_CODE(rcode), .TRANSFER_DATA_READY(tdr), .TRANSFER_TIMEOUT_WARNING(warn));

    servo_ctrl_model #(.STATION(8'h05)) ctrl (
        .core_clk(core_clk), .arst_n(arst_n), .ready_out(ready), .reply_valid(rvalid),
        .reply_char(rchar), .reply_last(rlast), .reply_error(rerr), .reply_err_code(rcode),
        .kick(kick), .kick_station(kst), .kick_cmd(kcmd), .kick_ferr(kferr), .read_req(rreq),
        .read_station(rst_s), .read_cmd(rcmd), .read_data_no(rdno), .read_frame_err(rferr),
        .got_pos(gpos), .got_code(gcode), .reads(reads), .errs(errs), .tmos(tmos));

    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // Advance k edges, then settle just after the last one
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step
    function automatic logic pick(input int s);
        return (s == 0) ? base_on : (s == 1) ? ready : warn;
    endfunction : pick
    // Count cycles until a chosen output goes high
    task automatic wait_hi(input int s, input int lim);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_hi
    task automatic pulse(input bit fb, input int k);
        repeat (k) begin
            if (fb) fpul = 1'b1;
            else cpul = 1'b1;
            step(1);
            {fpul, cpul} = 2'b00;
            step(1);
        end
    endtask : pulse
    // Start the drive, time base and ready, then check the automatic read
    task automatic power_up(input int d);
        r0 = reads;
        servo_on_input = 1'b1;
        estop = 1'b0;
        wait_hi(0, d * M + 20);
        check("base_dly", (n >= (d - 1) * M - 1) && (n <= d * M + 2), 1);
        check("ready_early", ready, 0);
        wait_hi(1, 40);
        check("ready_dly", (n >= 4 * M - 1) && (n <= 5 * M + 2), 1);
        step(15);
        check("reads", reads, r0 + 1);
        check("reply_pos", gpos, POS);
        check("pos_cmd", pcmd, POS);
        check("droop_read", droop, 0);
    endtask : power_up
    task automatic do_kick(input logic [7:0] st, input logic [7:0] cmd, input logic fe);
        {kst, kcmd, kferr, kick} = {st, cmd, fe, 1'b1};
        step(1);
        kick = 1'b0;
        step(40);
    endtask : do_kick

    // Main sequence
    initial begin
        {arst_n, servo_on_input, estop, alarm, fwd, rev, cpul, cdir, fpul, fdir} = '0;
        {mode, preq, kick, kferr, kst, kcmd} = '0;
        {fail_count, total_checks} = '0;
        step(4);
        arst_n = 1'b1;
        step(1);
        check("rst_outs", {base_on, ready, rvalid, warn}, 0);
        check("rst_droop", droop, 0);
        fdir = 1'b1;
        pulse(1, 10);
        power_up(95);
        pulse(0, 3);
        check("droop_run", droop, 3);
        cdir = 1'b1;
        pulse(0, 1);
        check("droop_neg", droop, 2);
        cdir = 1'b0;
        fwd = 1'b1;
        step(1);
        check("limit_halt", {inhibit, halt}, 2'b11);
        check("limit_droop", droop, 0);
        pulse(0, 2);
        check("limit_refuse", droop, 0);
        fwd = 1'b0;
        step(2);
        check("limit_free", {inhibit, halt}, 0);
        rev = 1'b1;
        step(1);
        check("limit_rev", {inhibit, halt}, 2'b11);
        rev = 1'b0;
        servo_on_input = 1'b0;
        step(1);
        check("son_off", {base_on, ready}, 0);
        step(3);
        power_up(95);
        // Bad frame, then bad command code: error code, then retried read
        for (int i = 0; i < 2; i++) begin
            {r0, e0} = {reads, errs};
            do_kick(8'h05, (i == 0) ? 8'h02 : 8'h07, i == 0);
            check("err_cnt", errs, e0 + 1);
            check("err_code", gcode, 8'h01);
            check("retry_read", reads, r0 + 1);
        end
        {r0, e0} = {reads, tmos};
        do_kick(8'h06, 8'h02, 1'b0);
        check("other_station", tmos, e0 + 1);
        check("tmo_read", reads, r0 + 1);
        estop = 1'b1;
        step(1);
        check("estop_off", {base_on, ready}, 0);
        step(10);
        power_up(210);
        alarm = 1'b1;
        step(1);
        check("alarm", {alarm_o, base_on}, 2'b10);
        servo_on_input = 1'b0;
        alarm = 1'b0;
        step(3);
        power_up(95);
        mode = 1'b1;
        step(1);
        check("tdr_on", tdr, 1);
        // Eighteen more request handshakes make nineteen ready rises
        for (int i = 0; i < 18; i++) begin
            preq = 1'b1;
            step(1);
            check("tdr_req", tdr, 0);
            preq = 1'b0;
            step(1);
            check("tdr_back", tdr, 1);
        end
        wait_hi(2, 5000 * M + 20);
        check("warn_dly", (n >= 4999 * M - 2) && (n <= 5000 * M + 3), 1);
        check("tdr_rises", tdr_rises, 19);
        check("tdr_low", tdr_low_max < 1000 * M, 1);
        check("req_high", req_hi_max < 1000 * M, 1);
        check("mode_time", mode_hi_n > 5000 * M, 1);
        mode = 1'b0;
        step(2);
        mode = 1'b1;
        step(2);
        check("warn_clear", warn, 0);
        stop_test();
    end
endmodule : servo_position_readout_seq_tb
